// file: hw/fpec_pkg.sv
// Package of constants and types for the flash program/erase control block
package fpec_pkg;

  // ==========================================================
  // Register addresses (low byte of the shared window)
  localparam logic [7:0] FPEC_ADDR_MODE_CONTROL = 8'h80;
  localparam logic [7:0] FPEC_ADDR_SETUP_ERROR = 8'h81;
  localparam logic [7:0] FPEC_ADDR_BLOCK_HIGH = 8'h82;
  localparam logic [7:0] FPEC_ADDR_BLOCK_LOW = 8'h83;

  // ==========================================================
  // Reset values
  localparam logic [7:0] FPEC_RST_MODE_CONTROL = 8'h80;
  localparam logic [7:0] FPEC_RST_SETUP_ERROR = 8'h00;
  localparam logic [7:0] FPEC_RST_BLOCK = 8'h00;
  localparam logic [7:0] FPEC_READ_DISABLED = 8'h00;

  // ==========================================================
  // Field positions
  localparam int FPEC_BIT_HW_WE = 7;
  localparam int FPEC_BIT_SW_WE = 6;
  localparam int FPEC_BIT_ERASE_VERIFY = 3;
  localparam int FPEC_BIT_PROGRAM_VERIFY = 2;
  localparam int FPEC_BIT_ERASE_RUN = 1;
  localparam int FPEC_BIT_PROGRAM_RUN = 0;
  localparam int FPEC_BIT_FLASH_ERROR = 7;
  localparam int FPEC_BIT_ERASE_SETUP = 1;
  localparam int FPEC_BIT_PROGRAM_SETUP = 0;
  localparam int FPEC_NUM_BLOCKS = 10;
  // Blocks 7..9 locked in normal CPU mode
  localparam logic [9:0] FPEC_NORMAL_MODE_MASK = 10'h07f;

  // ==========================================================
  // Block start addresses, 17-bit flash byte address
  localparam logic [16:0] FPEC_BLOCK_BASE [FPEC_NUM_BLOCKS] = '{
    17'h00000, 17'h00400, 17'h00800, 17'h00c00, 17'h01000,
    17'h08000, 17'h0c000, 17'h0e000, 17'h10000, 17'h18000};

  // ==========================================================
  // Bus access cycle: two states per byte access
  localparam int FPEC_ACCESS_STATES = 2;

  typedef enum logic [1:0] {
    FPEC_ST_IDLE = 2'b01,
    FPEC_ST_SECOND = 2'b10
  } fpec_bus_state_t;

  // Level outputs to the flash array controller
  typedef struct packed {
    logic program_run;
    logic erase_run;
    logic program_verify;
    logic erase_verify;
    logic [9:0] block_select;
  } fpec_array_ctrl_t;

endpackage

// file: hw/fpec_block_map.sv
// Maps a one-hot block selection to its start address and a block-selected flag
`timescale 1ns/1ps
`default_nettype none
module fpec_block_map (
  input wire logic [9:0] block_select,
  output logic [16:0] erase_base,
  output logic erase_any
);

  // ==========================================================
  // Lowest set bit wins; software keeps only one set
  always_comb begin
    erase_base = 17'h00000;
    erase_any = 1'b0;
    for (int i = fpec_pkg::FPEC_NUM_BLOCKS - 1; i >= 0; i--) begin
      if (block_select[i]) begin
        erase_base = fpec_pkg::FPEC_BLOCK_BASE[i];
        erase_any = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/fpec_control.sv
// Flash program/erase control register set with two-state byte bus
`timescale 1ns/1ps
`default_nettype none
module fpec_control (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic low_power_entry,
  input wire logic flash_enabled,
  input wire logic normal_cpu_mode,
  input wire logic flash_register_select,
  input wire logic program_erase_error,
  input wire logic bus_cs,
  input wire logic bus_we,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_ready,
  output fpec_pkg::fpec_array_ctrl_t array_ctrl,
  output logic [16:0] erase_base,
  output logic erase_protected
);

  // ==========================================================
  // Register state
  logic sw_we_ff, nxt_sw_we;
  logic ev_ff, nxt_ev;
  logic pv_ff, nxt_pv;
  logic erun_ff, nxt_erun;
  logic prun_ff, nxt_prun;
  logic esu_ff, nxt_esu;
  logic psu_ff, nxt_psu;
  logic flash_error_flag_ff, nxt_flash_error_flag;
  logic [9:0] blk_ff, nxt_blk;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ready_ff, nxt_ready;
  fpec_pkg::fpec_bus_state_t state_ff, nxt_state;
  fpec_pkg::fpec_array_ctrl_t array_ff, nxt_array;
  logic [16:0] base_ff, nxt_base;
  logic prot_ff, nxt_prot;
  logic [16:0] map_base;
  logic map_any;
  logic [9:0] blk_mask;
  logic hit, wr_now, rd_now;

  // ==========================================================
  // Decode helper
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  fpec_block_map u_map (
    .block_select(blk_ff),
    .erase_base(map_base),
    .erase_any(map_any)
  );

  // ==========================================================
  // Bus cycle: request taken in first state, completed in second
  // Window decode happens only with register select set
  assign hit = flash_register_select
    & (bus_addr[7:2] == fpec_pkg::FPEC_ADDR_MODE_CONTROL[7:2]);
  assign wr_now = (state_ff == fpec_pkg::FPEC_ST_SECOND) & bus_we & hit & flash_enabled;
  assign rd_now = (state_ff == fpec_pkg::FPEC_ST_SECOND) & ~bus_we & hit;
  assign blk_mask = normal_cpu_mode ? fpec_pkg::FPEC_NORMAL_MODE_MASK : 10'h3ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_ready = 1'b0;
    unique case (state_ff)
      fpec_pkg::FPEC_ST_IDLE: begin
        // Strobe still up in the ready cycle belongs to the finished access
        if (bus_cs && !ready_ff) begin
          nxt_state = fpec_pkg::FPEC_ST_SECOND;
        end
      end
      fpec_pkg::FPEC_ST_SECOND: begin
        nxt_state = fpec_pkg::FPEC_ST_IDLE;
        nxt_ready = 1'b1;
      end
      default: begin
        nxt_state = fpec_pkg::FPEC_ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Register next-state
  always_comb begin
    nxt_sw_we = sw_we_ff;
    nxt_ev = ev_ff;
    nxt_pv = pv_ff;
    nxt_erun = erun_ff;
    nxt_prun = prun_ff;
    nxt_esu = esu_ff;
    nxt_psu = psu_ff;
    nxt_blk = blk_ff;
    // Error flag is sticky; only reset or standby clears it
    nxt_flash_error_flag = flash_error_flag_ff | program_erase_error;
    if (wr_now && addr_is(bus_addr, fpec_pkg::FPEC_ADDR_MODE_CONTROL)) begin
      nxt_sw_we = bus_wdata[fpec_pkg::FPEC_BIT_SW_WE];
      if (sw_we_ff) begin
        nxt_ev = bus_wdata[fpec_pkg::FPEC_BIT_ERASE_VERIFY];
        nxt_pv = bus_wdata[fpec_pkg::FPEC_BIT_PROGRAM_VERIFY];
      end
      if (sw_we_ff && esu_ff) begin
        nxt_erun = bus_wdata[fpec_pkg::FPEC_BIT_ERASE_RUN];
      end
      if (sw_we_ff && psu_ff) begin
        nxt_prun = bus_wdata[fpec_pkg::FPEC_BIT_PROGRAM_RUN];
      end
    end
    if (wr_now && addr_is(bus_addr, fpec_pkg::FPEC_ADDR_SETUP_ERROR) && sw_we_ff) begin
      nxt_esu = bus_wdata[fpec_pkg::FPEC_BIT_ERASE_SETUP];
      nxt_psu = bus_wdata[fpec_pkg::FPEC_BIT_PROGRAM_SETUP];
    end
    if (wr_now && addr_is(bus_addr, fpec_pkg::FPEC_ADDR_BLOCK_HIGH)) begin
      nxt_blk[9:8] = bus_wdata[1:0] & blk_mask[9:8];
    end
    if (wr_now && addr_is(bus_addr, fpec_pkg::FPEC_ADDR_BLOCK_LOW)) begin
      nxt_blk[7:0] = bus_wdata & blk_mask[7:0];
    end
    // Block selects cleared while software enable is low
    if (!nxt_sw_we) begin
      nxt_blk = 10'h000;
    end
    // Low-power entry: mode register to reset value, setup bits down
    if (low_power_entry) begin
      nxt_sw_we = 1'b0;
      nxt_ev = 1'b0;
      nxt_pv = 1'b0;
      nxt_erun = 1'b0;
      nxt_prun = 1'b0;
      nxt_esu = 1'b0;
      nxt_psu = 1'b0;
      nxt_blk = 10'h000;
    end
  end

  // ==========================================================
  // Read data and array levels
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_now) begin
      nxt_rdata = fpec_pkg::FPEC_READ_DISABLED;
      if (flash_enabled) begin
        if (addr_is(bus_addr, fpec_pkg::FPEC_ADDR_MODE_CONTROL)) begin
          nxt_rdata = {1'b1, sw_we_ff, 2'b00, ev_ff, pv_ff, erun_ff, prun_ff};
        end else if (addr_is(bus_addr, fpec_pkg::FPEC_ADDR_SETUP_ERROR)) begin
          nxt_rdata = {flash_error_flag_ff, 5'h00, esu_ff, psu_ff};
        end else if (addr_is(bus_addr, fpec_pkg::FPEC_ADDR_BLOCK_HIGH)) begin
          nxt_rdata = {6'h00, blk_ff[9:8] & blk_mask[9:8]};
        end else begin
          nxt_rdata = blk_ff[7:0] & blk_mask[7:0];
        end
      end
    end
    nxt_array.program_run = prun_ff;
    nxt_array.erase_run = erun_ff;
    nxt_array.program_verify = pv_ff;
    nxt_array.erase_verify = ev_ff;
    nxt_array.block_select = blk_ff & blk_mask;
    nxt_base = map_base;
    // Without a selected block, or in error protection, nothing erases
    nxt_prot = ~map_any | flash_error_flag_ff;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!resetn || hw_standby) begin
      sw_we_ff <= 1'b0;
      ev_ff <= 1'b0;
      pv_ff <= 1'b0;
      erun_ff <= 1'b0;
      prun_ff <= 1'b0;
      esu_ff <= 1'b0;
      psu_ff <= 1'b0;
      flash_error_flag_ff <= 1'b0;
      blk_ff <= 10'h000;
      rdata_ff <= 8'h00;
      ready_ff <= 1'b0;
      state_ff <= fpec_pkg::FPEC_ST_IDLE;
      array_ff <= '0;
      base_ff <= 17'h00000;
      prot_ff <= 1'b1;
    end else begin
      sw_we_ff <= nxt_sw_we;
      ev_ff <= nxt_ev;
      pv_ff <= nxt_pv;
      erun_ff <= nxt_erun;
      prun_ff <= nxt_prun;
      esu_ff <= nxt_esu;
      psu_ff <= nxt_psu;
      flash_error_flag_ff <= nxt_flash_error_flag;
      blk_ff <= nxt_blk;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      state_ff <= nxt_state;
      array_ff <= nxt_array;
      base_ff <= nxt_base;
      prot_ff <= nxt_prot;
    end
  end

  assign bus_rdata = rdata_ff;
  assign bus_ready = ready_ff;
  assign array_ctrl = array_ff;
  assign erase_base = base_ff;
  assign erase_protected = prot_ff;

endmodule
`default_nettype wire

// file: bench/fpec_control_checker.sv
// Checker for the flash program/erase control block ports
`timescale 1ns/1ps
`default_nettype none
module fpec_control_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic low_power_entry,
  input wire logic flash_enabled,
  input wire logic normal_cpu_mode,
  input wire logic flash_register_select,
  input wire logic program_erase_error,
  input wire logic bus_cs,
  input wire logic bus_we,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_ready,
  input wire fpec_pkg::fpec_array_ctrl_t array_ctrl,
  input wire logic [16:0] erase_base,
  input wire logic erase_protected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Bus timing and read values
  property p_ready; bus_ready |-> $past(bus_cs, 2) && !$past(bus_ready); endproperty
  a_ready: assert property (p_ready) else $error("ready not two states after request");
  property p_rd_hold; !bus_ready && !$past(hw_standby) |-> $stable(bus_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without ready");
  property p_mode_rd;
    bus_ready && !$past(bus_we) && $past(bus_addr) == 8'h80 && $past(flash_enabled) && $past(flash_register_select)
      |-> bus_rdata[7] && bus_rdata[5:4] == 2'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode control fixed bits wrong");
  property p_setup_rd;
    bus_ready && !$past(bus_we) && $past(bus_addr) == 8'h81 && $past(flash_register_select) |-> bus_rdata[6:2] == 5'h00;
  endproperty
  a_setup_rd: assert property (p_setup_rd) else $error("reserved setup bits nonzero");
  property p_off_rd;
    bus_ready && !$past(bus_we) && !$past(flash_enabled) && $past(flash_register_select) |-> bus_rdata == 8'h00;
  endproperty
  a_off_rd: assert property (p_off_rd) else $error("disabled flash read nonzero");
  // ==========================================================
  // Array levels
  property p_prot; array_ctrl.block_select == 10'h000 |-> erase_protected; endproperty
  a_prot: assert property (p_prot) else $error("unselected flash not protected");
  property p_base8; array_ctrl.block_select == 10'h100 |-> erase_base == 17'h10000; endproperty
  a_base8: assert property (p_base8) else $error("block 8 base wrong");
  property p_normal; normal_cpu_mode && $past(normal_cpu_mode, 2) |-> array_ctrl.block_select[9:7] == 3'h0; endproperty
  a_normal: assert property (p_normal) else $error("upper block selected in normal mode");
  property p_low; low_power_entry |-> ##2 array_ctrl == '0; endproperty
  a_low: assert property (p_low) else $error("low power left array active");
  property p_err; program_erase_error |-> ##2 erase_protected [*3]; endproperty
  a_err: assert property (p_err) else $error("error did not protect");
  c_prog: cover property (array_ctrl.program_run);
  c_erase: cover property (array_ctrl.erase_run);
  c_verify: cover property (array_ctrl.erase_verify);
endmodule
`default_nettype wire

// file: bench/fpec_cpu_model.sv
// CPU bus master model for the flash control registers
`timescale 1ns/1ps
`default_nettype none
module fpec_cpu_model (
  input wire logic clk,
  input wire logic bus_ready,
  output logic bus_cs = 1'b0,
  output logic bus_we = 1'b0,
  output logic [7:0] bus_addr = 8'h00,
  output logic [7:0] bus_wdata = 8'h00
);
  // Byte access: request and qualifiers held until ready is sampled high
  task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d, output logic ok);
    int n;
    @(posedge clk);
    #1;
    bus_cs = 1'b1;
    bus_we = we;
    bus_addr = a;
    bus_wdata = d;
    n = 0;
    @(posedge clk);
    while (bus_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    ok = n < 8;
    #1;
    bus_cs = 1'b0;
    // Released lines show garbage, not the last value
    bus_we = ~we;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// file: bench/flash_program_erase_control_tb.sv
// Testbench for the flash program/erase control block
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hw_standby = 1'b0, low_power_entry = 1'b0, flash_enabled = 1'b1, normal_cpu_mode = 1'b0;
  logic flash_register_select = 1'b1, program_erase_error = 1'b0;
  logic bus_cs, bus_we, bus_ready, erase_protected;
  logic [7:0] bus_addr, bus_wdata, bus_rdata;
  logic [16:0] erase_base;
  fpec_pkg::fpec_array_ctrl_t array_ctrl;
  logic [7:0] exp_q [$];
  int mismatches = 0;
  int checks = 0;
  localparam logic [16:0] bases [10] = '{17'h00000, 17'h00400, 17'h00800, 17'h00c00, 17'h01000,
    17'h08000, 17'h0c000, 17'h0e000, 17'h10000, 17'h18000};
  localparam logic [7:0] su [4] = '{8'h01, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] run [4] = '{8'h41, 8'h42, 8'h44, 8'h48};
  localparam logic [13:0] lv [4] = '{14'h2000, 14'h1000, 14'h0800, 14'h0400};
  fpec_control fpec_control_inst (.clk, .resetn, .hw_standby, .low_power_entry, .flash_enabled, .normal_cpu_mode,
    .flash_register_select, .program_erase_error, .bus_cs, .bus_we, .bus_addr, .bus_wdata, .bus_rdata,
    .bus_ready, .array_ctrl, .erase_base, .erase_protected);
  fpec_cpu_model fpec_cpu_model_inst (.clk, .bus_ready, .bus_cs, .bus_we, .bus_addr, .bus_wdata);
  initial forever #20 clk = ~clk;
  // ==========================================================
  // Reporting and bus tasks
  task automatic results();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    fpec_cpu_model_inst.access(we, a, d, ok);
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t no ready", $time);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    if (bus_ready === 1'b1 && bus_we === 1'b0) cmp("rdata", 17'(bus_rdata), 17'(exp_q.pop_front()));
  end
  // ==========================================================
  // Main sequence
  initial begin
    int s, b;
    logic [9:0] bs;
    logic [7:0] ra, rv;
    s = $urandom(5624);
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    rd(8'h80, 8'h80);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h00);
    wr(8'h80, 8'h0f);
    wr(8'h81, 8'h03);
    wr(8'h83, 8'hff);
    rd(8'h80, 8'h80);
    rd(8'h81, 8'h00);
    rd(8'h83, 8'h00);
    wr(8'h80, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(8'h81, su[m]);
      wr(8'h80, run[m]);
      rd(8'h80, 8'h80 | run[m]);
      cmp("array", 17'(array_ctrl), 17'(lv[m]));
      wr(8'h80, 8'h40);
      wr(8'h81, 8'h00);
    end
    cmp("array", 17'(array_ctrl), 17'h0);
    wr(8'h80, 8'h70);
    rd(8'h80, 8'hc0);
    wr(8'h81, 8'hfc);
    rd(8'h81, 8'h00);
    s = $urandom % 10;
    for (int k = 0; k < 10; k++) begin
      b = (s + k) % 10;
      bs = 10'h001 << b;
      ra = b > 7 ? 8'h82 : 8'h83;
      rv = b > 7 ? 8'(bs[9:8]) : bs[7:0];
      wr(ra, rv);
      rd(ra, rv);
      cmp("base", erase_base, bases[b]);
      cmp("prot", 17'(erase_protected), 17'h0);
      wr(ra, 8'h00);
    end
    normal_cpu_mode = 1'b1;
    wr(8'h82, 8'h03);
    rd(8'h82, 8'h00);
    wr(8'h83, 8'h80);
    rd(8'h83, 8'h00);
    normal_cpu_mode = 1'b0;
    wr(8'h83, 8'h01);
    wr(8'h80, 8'h00);
    rd(8'h83, 8'h00);
    flash_register_select = 1'b0;
    wr(8'h80, 8'h40);
    flash_register_select = 1'b1;
    rd(8'h80, 8'h80);
    flash_enabled = 1'b0;
    rd(8'h80, 8'h00);
    wr(8'h80, 8'h40);
    flash_enabled = 1'b1;
    rd(8'h80, 8'h80);
    wr(8'h80, 8'h40);
    wr(8'h81, 8'h02);
    wr(8'h83, 8'h10);
    low_power_entry = 1'b1;
    @(posedge clk) #1 low_power_entry = 1'b0;
    rd(8'h81, 8'h00);
    rd(8'h80, 8'h80);
    // Select a block first so only the error flag can protect
    wr(8'h80, 8'h40);
    wr(8'h83, 8'h01);
    cmp("prot", 17'(erase_protected), 17'h0);
    program_erase_error = 1'b1;
    @(posedge clk) #1 program_erase_error = 1'b0;
    rd(8'h81, 8'h80);
    cmp("prot", 17'(erase_protected), 17'h1);
    hw_standby = 1'b1;
    @(posedge clk) #1 hw_standby = 1'b0;
    rd(8'h81, 8'h00);
    results();
  end
endmodule
bind fpec_control fpec_control_checker fpec_control_checker_inst (.*);
`default_nettype wire
